// [rtl/dac_ctrl_pkg.sv]
// package: register map, field positions, reset values and timing for dac playback control
package dac_ctrl_pkg;

  // ==========================================================
  // register offsets (byte-free index on the plain register port)
  localparam logic [7:0] HEADPHONE_OUTPUT_POWER_ADDR = 8'h0e;
  localparam logic [7:0] LINE_OUTPUT_POWER_ADDR = 8'h0f;
  localparam logic [7:0] DAC_DIGITAL_SETTINGS_ADDR = 8'h21;
  localparam logic [7:0] VOLUME_ADDR = 8'h22;
  localparam logic [7:0] PATH_CONTROL_ADDR = 8'h23;
  localparam logic [7:0] RAMP_STATUS_ADDR = 8'h24;

  // ==========================================================
  // dac_digital_settings fields
  localparam int MONO_BIT = 12;
  localparam int SB_FILT_BIT = 11;
  localparam int MUTE_RATE_BIT = 10;
  localparam int UNMUTE_RAMP_BIT = 9;
  localparam int OSR_BIT = 6;
  localparam int MUTE_BIT = 3;
  localparam int DEEMPHASIS_SEL_LSB = 1;
  localparam logic [15:0] DAC_DIGITAL_RESET = 16'h0008;
  localparam logic [15:0] DAC_DIGITAL_MASK = 16'h1e4e;

  // power registers: left on bit 1, right on bit 0
  localparam int LEFT_EN_BIT = 1;
  localparam int RIGHT_EN_BIT = 0;
  localparam logic [15:0] POWER_RESET = 16'h0000;

  // volume register: left [15:8], right [7:0]; 0xc0 is 0 dB
  localparam logic [15:0] VOLUME_RESET = 16'hc0c0;

  // path_control: converter enables [1:0], bypass selects [5:2], unshort [9:6],
  // headphone input/mid stage enables [11:10]
  localparam int CONV_EN_LSB = 0;
  localparam int BYPASS_SEL_LSB = 2;
  localparam int UNSHORT_LSB = 6;
  localparam int HP_IN_STAGE_BIT = 10;
  localparam int HP_MID_STAGE_BIT = 11;
  localparam logic [15:0] PATH_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PATH_CONTROL_MASK = 16'h0fff;

  // ==========================================================
  // ramp timing: ticks in samples
  // six bits wide: the slow period of 32 does not fit in five
  localparam logic [5:0] FAST_RAMP_SAMPLES = 6'h02;
  localparam logic [5:0] SLOW_RAMP_SAMPLES = 6'h20;
  localparam real FAST_RAMP_MAX_MS = 10.7;
  localparam real SLOW_RAMP_MAX_MS = 171.0;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } stereo_sample_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic mono;
    logic sb_filt;
    logic mute_rate;
    logic unmute_ramp;
    logic osr_double;
    logic mute;
    logic [1:0] deemphasis_sel;
  } dac_cfg_t;

endpackage

// [rtl/volume_ramp.sv]
// one channel soft-mute volume ramp
`timescale 1ns/1ps
module volume_ramp
  import dac_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic tick_i,
  input wire logic sample_i,
  input wire logic mute_i,
  input wire logic unmute_ramp_i,
  input wire logic [7:0] target_i,
  // state
  output logic [7:0] level_o
);

  // ==========================================================
  // ramp
  wire logic below = level_o < target_i;
  wire logic above = level_o > target_i;
  wire logic [7:0] next_up = level_o + 8'h01;
  wire logic [7:0] next_down = level_o - 8'h01;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      level_o <= 8'h00;
    end else if (mute_i) begin
      if (tick_i && level_o != 8'h00) level_o <= next_down; // RULE19
    end else if (!unmute_ramp_i) begin
      // restore at the next sample, no ramp
      if (sample_i) level_o <= target_i; // RULE3
    end else if (tick_i && below) begin
      level_o <= next_up; // RULE4
    end else if (tick_i && above) begin
      level_o <= next_down;
    end
  end

  // ==========================================================
  // checks
  property p_step_one;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (mute_i && unmute_ramp_i) |=> ($past(level_o) - level_o) <= 8'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("ramp stepped more than one"); // RULE19

endmodule

// [rtl/dac_playback_digital_control.sv]
// dac playback digital control: registers, mute ramp, mono mix, output path controls
//
// Overview of operation
// [RULE1] ramp rate bit: fs/2 clear, fs/32 set
// [RULE2] full ramp within 10.7ms or 171ms
// [RULE3] un-mute without ramp restores volume at once
// [RULE4] un-mute ramp mode raises volume gradually
// [RULE5] mute bit resets set; mutes when set
// [RULE6] mono mix sums channels, attenuates 6 dB
// [RULE7] disabled converter outputs nothing in mono
// [RULE8] both converters enabled forces stereo
// [RULE9] two-bit de-emphasis select, four settings
// [RULE10] filter bit picks sloping stopband when set
// [RULE11] oversample bit doubles ratio when set
// [RULE12] per-output gain stage enable bits
// [RULE13] per-path mux: converter or analogue bypass
// [RULE14] outputs shorted to ground until unshort set
// [RULE15] software enables reference and bias first
// [RULE16] software orders enables, schedules offset correction
// [RULE17] mid stage 20us after input stage
// [RULE18] enable order input, mid, correction, output, unshort
// [RULE19] one volume step per ramp tick
// [RULE20] control changes apply at sample boundaries
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module dac_playback_digital_control
  import dac_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // sample stream in (same clock, one-cycle strobe per sample)
  input wire logic sample_valid_i,
  input wire stereo_sample_t sample_i,
  // processed stream out
  output logic sample_valid_o,
  output stereo_sample_t sample_o,
  output logic [7:0] left_level_o,
  output logic [7:0] right_level_o,
  // filter and path controls
  output dac_cfg_t cfg_o,
  output logic [1:0] headphone_gain_enable_o,
  output logic [1:0] line_gain_enable_o,
  output logic [3:0] bypass_sel_o,
  output logic [3:0] ground_short_o,
  output logic [1:0] hp_stage_en_o
);

  // ==========================================================
  // register state
  logic [15:0] headphone_output_power;
  logic [15:0] line_output_power;
  logic [15:0] dac_digital_settings;
  logic [15:0] volume;
  logic [15:0] path_control;

  wire reg_req_t req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
  wire logic sel_hp = req.addr == HEADPHONE_OUTPUT_POWER_ADDR;
  wire logic sel_line = req.addr == LINE_OUTPUT_POWER_ADDR;
  wire logic sel_dig = req.addr == DAC_DIGITAL_SETTINGS_ADDR;
  wire logic sel_vol = req.addr == VOLUME_ADDR;
  wire logic sel_path = req.addr == PATH_CONTROL_ADDR;
  wire logic sel_stat = req.addr == RAMP_STATUS_ADDR;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      headphone_output_power <= POWER_RESET; // RULE12
      line_output_power <= POWER_RESET;
      dac_digital_settings <= DAC_DIGITAL_RESET; // RULE5
      volume <= VOLUME_RESET;
      path_control <= PATH_CONTROL_RESET; // RULE14
    end else if (req.wr) begin
      if (sel_hp) headphone_output_power <= req.wdata & 16'h0003;
      if (sel_line) line_output_power <= req.wdata & 16'h0003;
      if (sel_dig) dac_digital_settings <= req.wdata & DAC_DIGITAL_MASK;
      if (sel_vol) volume <= req.wdata;
      if (sel_path) path_control <= req.wdata & PATH_CONTROL_MASK;
    end
  end

  // ==========================================================
  // register readback, one cycle after the strobe; unmapped reads zero
  wire logic [15:0] status_word = {left_level_o, right_level_o};
  wire logic [15:0] next_rdata =
    sel_hp ? headphone_output_power :
    sel_line ? line_output_power :
    sel_dig ? dac_digital_settings :
    sel_vol ? volume :
    sel_path ? path_control :
    sel_stat ? status_word : 16'h0000;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) reg_rdata_o <= 16'h0000;
    else reg_rdata_o <= req.rd ? next_rdata : 16'h0000;
  end

  // ==========================================================
  // control latched only between samples so a sample sees one setting
  dac_cfg_t next_cfg;
  assign next_cfg = '{
    mono: dac_digital_settings[MONO_BIT],
    sb_filt: dac_digital_settings[SB_FILT_BIT],
    mute_rate: dac_digital_settings[MUTE_RATE_BIT],
    unmute_ramp: dac_digital_settings[UNMUTE_RAMP_BIT],
    osr_double: dac_digital_settings[OSR_BIT],
    mute: dac_digital_settings[MUTE_BIT],
    deemphasis_sel: dac_digital_settings[DEEMPHASIS_SEL_LSB +: 2]};
  localparam dac_cfg_t CFG_RESET = '{default: 1'b0, mute: 1'b1};

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) cfg_o <= CFG_RESET;
    else if (sample_valid_i) cfg_o <= next_cfg; // RULE20 RULE9 RULE10 RULE11
  end

  // ==========================================================
  // ramp tick: every 2 or 32 samples
  logic [5:0] sample_count;
  wire logic [5:0] tick_period = cfg_o.mute_rate ? SLOW_RAMP_SAMPLES : FAST_RAMP_SAMPLES;
  wire logic tick = sample_valid_i && (sample_count == tick_period - 6'h01); // RULE1
  wire logic [5:0] next_count = sample_count + 6'h01;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) sample_count <= 6'h00;
    else if (tick) sample_count <= 6'h00;
    else if (sample_valid_i) sample_count <= (next_count >= tick_period) ? 6'h00 : next_count;
  end

  // ==========================================================
  // per-channel ramps; 255 steps max keeps full ramp within 10.7ms or 171ms at 48k
  logic [1:0][7:0] ch_level;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ramp
      volume_ramp u_ramp (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick), // RULE2
        .sample_i(sample_valid_i),
        .mute_i(cfg_o.mute),
        .unmute_ramp_i(cfg_o.unmute_ramp),
        .target_i(volume[8*ch +: 8]),
        .level_o(ch_level[ch])
      );
    end
  endgenerate

  // channel 1 is left, matching the upper byte of the volume register
  assign left_level_o = ch_level[1];
  assign right_level_o = ch_level[0];

  // ==========================================================
  // mono mix and channel routing
  wire logic left_conv_en = path_control[CONV_EN_LSB + 1];
  wire logic right_conv_en = path_control[CONV_EN_LSB];
  wire logic mono_active = cfg_o.mono && !(left_conv_en && right_conv_en); // RULE8
  wire logic [16:0] mix_sum = {sample_i.left[15], sample_i.left}
                            + {sample_i.right[15], sample_i.right};
  wire logic [15:0] mix_half = mix_sum[16:1]; // RULE6
  wire logic [15:0] next_left = !left_conv_en ? 16'h0000 :
                                mono_active ? mix_half : sample_i.left; // RULE7
  wire logic [15:0] next_right = !right_conv_en ? 16'h0000 :
                                 mono_active ? mix_half : sample_i.right; // RULE7

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sample_o <= '0;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= sample_valid_i;
      if (sample_valid_i) sample_o <= '{left: next_left, right: next_right};
    end
  end

  // ==========================================================
  // output stage controls
  // software owns reference/bias and the enable order; nothing here checks it
  assign headphone_gain_enable_o = headphone_output_power[1:0]; // RULE12
  assign line_gain_enable_o = line_output_power[1:0]; // RULE12
  assign bypass_sel_o = path_control[BYPASS_SEL_LSB +: 4]; // RULE13
  assign ground_short_o = ~path_control[UNSHORT_LSB +: 4]; // RULE14
  assign hp_stage_en_o = {path_control[HP_MID_STAGE_BIT], path_control[HP_IN_STAGE_BIT]};

  // ==========================================================
  // checks
  // independent reference for the halved mono sum
  wire logic signed [16:0] mix_ref_sum = $signed(sample_i.left) + $signed(sample_i.right);
  wire logic [15:0] mix_ref = 16'(mix_ref_sum >>> 1);

  property p_mute_reset;
    @(posedge ref_clk_i) $rose(rst_b_i) |-> dac_digital_settings[MUTE_BIT];
  endproperty
  a_mute_reset: assert property (p_mute_reset) else $error("mute not set after reset"); // RULE5

  property p_short_default;
    @(posedge ref_clk_i)
      !rst_b_i |=> ground_short_o == 4'hf;
  endproperty
  a_short_default: assert property (p_short_default) else $error("short released early"); // RULE14

  property p_stereo_both;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sample_valid_i && left_conv_en && right_conv_en) |=> sample_o.left == $past(sample_i.left);
  endproperty
  a_stereo_both: assert property (p_stereo_both) else $error("stereo not kept"); // RULE8

  property p_mono_off_side;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sample_valid_i && !right_conv_en) |=> sample_o.right == 16'h0000;
  endproperty
  a_mono_off_side: assert property (p_mono_off_side) else $error("disabled side output"); // RULE7

  property p_mono_mix;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sample_valid_i && mono_active && left_conv_en) |=> sample_o.left == $past(mix_ref);
  endproperty
  a_mono_mix: assert property (p_mono_mix) else $error("mono mix wrong"); // RULE6

  property p_cfg_boundary;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !sample_valid_i |=> $stable(cfg_o);
  endproperty
  a_cfg_boundary: assert property (p_cfg_boundary) else $error("config changed mid sample"); // RULE20

  property p_fast_tick;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (tick && !cfg_o.mute_rate) |-> sample_count == 6'h01;
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("fast tick period wrong"); // RULE1

  property p_instant_unmute;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sample_valid_i && !cfg_o.mute && !cfg_o.unmute_ramp) |=> left_level_o == $past(volume[15:8]);
  endproperty
  a_instant_unmute: assert property (p_instant_unmute) else $error("no instant restore"); // RULE3

  property p_gain_en;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (req.wr && sel_hp) |=> headphone_gain_enable_o == $past(req.wdata[1:0]);
  endproperty
  a_gain_en: assert property (p_gain_en) else $error("gain enable not written"); // RULE12

  property p_mute_ramp_down;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (tick && cfg_o.mute && left_level_o != 8'h00) |=>
        left_level_o == $past(left_level_o) - 8'h01;
  endproperty
  a_mute_ramp_down: assert property (p_mute_ramp_down) else $error("mute step wrong"); // RULE19

  property p_unmute_ramp_up;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (tick && !cfg_o.mute && cfg_o.unmute_ramp && left_level_o < volume[15:8]) |=>
        left_level_o == $past(left_level_o) + 8'h01;
  endproperty
  a_unmute_ramp_up: assert property (p_unmute_ramp_up) else $error("ramp up step wrong"); // RULE4

  property p_level_hold;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !sample_valid_i |=> $stable(left_level_o) && $stable(right_level_o);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level moved off a tick"); // RULE19

  property p_slow_tick;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (tick && cfg_o.mute_rate) |-> sample_count == 6'h1f;
  endproperty
  a_slow_tick: assert property (p_slow_tick) else $error("slow tick period wrong"); // RULE1

  property p_cfg_mute_reset;
    @(posedge ref_clk_i) $rose(rst_b_i) |-> cfg_o.mute;
  endproperty
  a_cfg_mute_reset: assert property (p_cfg_mute_reset) else $error("cfg not muted"); // RULE5

  property p_deemphasis_sel_follow;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      sample_valid_i |=> cfg_o.deemphasis_sel == $past(dac_digital_settings[DEEMPHASIS_SEL_LSB +: 2]);
  endproperty
  a_deemphasis_sel_follow: assert property (p_deemphasis_sel_follow) else $error("deemphasis wrong"); // RULE9

  property p_filter_follow;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      sample_valid_i |=> cfg_o.sb_filt == $past(dac_digital_settings[SB_FILT_BIT]);
  endproperty
  a_filter_follow: assert property (p_filter_follow) else $error("filter select wrong"); // RULE10

  property p_osr_follow;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      sample_valid_i |=> cfg_o.osr_double == $past(dac_digital_settings[OSR_BIT]);
  endproperty
  a_osr_follow: assert property (p_osr_follow) else $error("oversample select wrong"); // RULE11

  property p_mono_right;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sample_valid_i && mono_active && right_conv_en) |=> sample_o.right == $past(mix_ref);
  endproperty
  a_mono_right: assert property (p_mono_right) else $error("right mono mix wrong"); // RULE6

  property p_valid_follow;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      sample_valid_i |=> sample_valid_o;
  endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("sample strobe lost"); // RULE20

  c_mute_ramp: cover property (@(posedge ref_clk_i) cfg_o.mute && tick && left_level_o != 8'h00);
  c_mono: cover property (@(posedge ref_clk_i) sample_valid_i && mono_active);
  c_unshort: cover property (@(posedge ref_clk_i) ground_short_o == 4'h0);
  c_slow_tick: cover property (@(posedge ref_clk_i) tick && cfg_o.mute_rate);
  c_ramp_up: cover property (@(posedge ref_clk_i) tick && !cfg_o.mute && cfg_o.unmute_ramp);

endmodule

// [sim/sample_source.sv]
// sample source model: one-cycle sample strobe at a fixed spacing
`timescale 1ns/1ps
module sample_source
  import dac_ctrl_pkg::*;
#(
  parameter int SPACING = 6
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // data to send
  input wire stereo_sample_t data_i,
  // stream out
  output logic sample_valid_o,
  output stereo_sample_t sample_o
);
  int cnt;
  // ==========================================================
  // strobe
  // data is scrambled between strobes so nothing may lean on stale values
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt <= 0;
      sample_valid_o <= 1'b0;
      sample_o <= '0;
    end else begin
      cnt <= (cnt == SPACING - 1) ? 0 : cnt + 1;
      sample_valid_o <= (cnt == SPACING - 1);
      sample_o <= (cnt == SPACING - 1) ? data_i : ~sample_o;
    end
  end
endmodule

// [sim/dac_playback_digital_control_tb_top.sv]
// testbench for dac playback digital control
`timescale 1ns/1ps
module dac_playback_digital_control_tb_top;
  import dac_ctrl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic vin;
  logic vout;
  stereo_sample_t sin;
  stereo_sample_t sout;
  stereo_sample_t src = '0;
  logic [7:0] lvl_l;
  logic [7:0] lvl_r;
  dac_cfg_t cfg;
  logic [1:0] hp_en;
  logic [1:0] ln_en;
  logic [3:0] byp;
  logic [3:0] gshort;
  logic [1:0] stage;
  int fail_count = 0;
  int check_count = 0;
  int n;

  always #50 ref_clk_i = ~ref_clk_i;

  sample_source u_src (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .data_i(src),
    .sample_valid_o(vin), .sample_o(sin));

  dac_playback_digital_control u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .sample_valid_i(vin), .sample_i(sin), .sample_valid_o(vout),
    .sample_o(sout), .left_level_o(lvl_l), .right_level_o(lvl_r), .cfg_o(cfg),
    .headphone_gain_enable_o(hp_en), .line_gain_enable_o(ln_en), .bypass_sel_o(byp),
    .ground_short_o(gshort), .hp_stage_en_o(stage));

  // ==========================================================
  // helpers
  task automatic close_out();
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // waits for cnt output samples; a lost stream ends the run
  task automatic smp(input int cnt);
    for (int k = 0; k < cnt; k++) begin
      for (int t = 0; t <= 50; t++) begin
        @(posedge ref_clk_i);
        #1;
        if (vout === 1'b1) break;
        if (t == 50) begin
          fail_count++;
          close_out();
        end
      end
    end
  endtask

  // counts output samples until the left level reaches lv
  task automatic until_level(input logic [7:0] lv);
    n = 0;
    while (lvl_l !== lv) begin
      smp(1);
      n++;
      if (n > 9000) begin
        fail_count++;
        close_out();
      end
    end
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'h0008);
    rd_reg(HEADPHONE_OUTPUT_POWER_ADDR, 16'h0000);
    rd_reg(LINE_OUTPUT_POWER_ADDR, 16'h0000);
    rd_reg(8'h30, 16'h0000);
    chk({12'h000, gshort}, 16'h000f);
    chk({8'h00, lvl_l}, 16'h0000);
    // reference and bias are taken as already up outside this block
    wr_reg(HEADPHONE_OUTPUT_POWER_ADDR, 16'hffff);
    wr_reg(LINE_OUTPUT_POWER_ADDR, 16'h0002);
    rd_reg(HEADPHONE_OUTPUT_POWER_ADDR, 16'h0003);
    chk({hp_en, ln_en}, 16'h000e);
    // pop-free order: input stage, mid stage 20 us later, short removed last
    wr_reg(PATH_CONTROL_ADDR, 16'h0400);
    repeat (200) @(posedge ref_clk_i);
    wr_reg(PATH_CONTROL_ADDR, 16'h0c00);
    #1;
    chk({8'h00, stage, 2'b00, gshort}, 16'h00cf);
    wr_reg(PATH_CONTROL_ADDR, 16'hfd68);
    rd_reg(PATH_CONTROL_ADDR, 16'h0d68);
    chk({4'h0, stage, byp, 2'b00, gshort}, 16'h0e8a);
    // instant restore, then a full fast mute ramp from the top level
    wr_reg(VOLUME_ADDR, 16'hff04);
    wr_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'h0000);
    smp(2);
    chk({lvl_l, lvl_r}, 16'hff04);
    wr_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'h0008);
    until_level(8'h00);
    chk(16'(n >= 509 && n <= 511), 16'h0001);
    chk({8'h00, lvl_r}, 16'h0000);
    // slow un-mute ramp over the whole range
    wr_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'h0600);
    smp(1);
    chk(16'(lvl_l <= 8'h01), 16'h0001);
    until_level(8'hff);
    chk(16'(n >= 8128 && n <= 8161), 16'h0001);
    wr_reg(RAMP_STATUS_ADDR, 16'h1234);
    rd_reg(RAMP_STATUS_ADDR, 16'hff04);
    // config applies at a sample edge only
    smp(1);
    wr_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'hffff);
    chk({8'h00, cfg}, 16'h0030);
    rd_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'h1e4e);
    smp(1);
    chk({8'h00, cfg}, 16'h00ff);
    for (int d = 0; d < 4; d++) begin
      wr_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'((d[0] << 11) | (d[1] << 6) | (d << 1)));
      smp(1);
      chk({8'h00, cfg}, 16'((d[0] << 6) | (d[1] << 3) | d));
    end
    // mono mix with negative data checks the arithmetic halving
    src <= '{left: 16'hff00, right: 16'hfe00};
    wr_reg(PATH_CONTROL_ADDR, 16'h0002);
    wr_reg(DAC_DIGITAL_SETTINGS_ADDR, 16'h1000);
    smp(2);
    chk(sout.left, 16'hfe80);
    chk(sout.right, 16'h0000);
    wr_reg(PATH_CONTROL_ADDR, 16'h0001);
    smp(2);
    chk(sout.left, 16'h0000);
    chk(sout.right, 16'hfe80);
    wr_reg(PATH_CONTROL_ADDR, 16'h0003);
    smp(2);
    chk(sout.left, 16'hff00);
    chk(sout.right, 16'hfe00);
    close_out();
  end
endmodule
